// *** include/lcd_decoder_defines.vh ***
`ifndef LCD_DECODER_DEFINES_VH
`define LCD_DECODER_DEFINES_VH

// Geometry
`define NUM_DISPLAY_BITS   140
`define NUM_SEGMENTS       35
`define NUM_COMMONS        4
`define NUM_SHARED         4

// Port-select codes
`define PS_NONE            3'h0
`define PS_ONE             3'h1
`define PS_TWO             3'h2
`define PS_THREE           3'h3
`define PS_ALL             3'h4

// Frame-rate codes and divisors
`define FR_768             3'h6
`define FR_576             3'h7
`define FR_384             3'h0
`define FR_288             3'h1
`define FR_192             3'h2
`define DIV_768            10'h300
`define DIV_576            10'h240
`define DIV_384            10'h180
`define DIV_288            10'h120
`define DIV_192            10'h0C0

// Inhibit release wait, applies to the controller side
`define INH_WAIT_NS        10000

// Reset values of the live waveform state
`define PHASE_RESET        2'h0
`define COUNT_RESET        10'h000

`endif

// *** tb/lcd_decoder_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcd_decoder_checker (
    input wire logic         MCLK, RST_B,
    input wire logic [139:0] DISPLAY_BITS,
    input wire logic [2:0]   PORT_SELECT,
    input wire logic         CLOCK_SOURCE_SELECT, SEGMENTS_OFF, POWER_SAVE, DISPLAY_INHIBIT_N,
    input wire logic         RC_OSC_ENABLE, OSC_PIN_OE,
    input wire logic [3:0]   SHARED_OUTPUT_PINS, SHARED_IS_GP, COMMON_OUTPUTS,
    input wire logic [30:0]  SEGMENT_OUTPUTS,
    input wire logic [1:0]   COMMON_PHASE
);
    // First edge after reset release is skipped: outputs are still cleared there
    logic       up_reg;
    wire  [3:0] gp_bits = {DISPLAY_BITS[12], DISPLAY_BITS[8], DISPLAY_BITS[4], DISPLAY_BITS[0]};
    wire        inh_n   = DISPLAY_INHIBIT_N;
    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) up_reg <= 1'b0;
        else up_reg <= 1'b1;
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    AST_INH_GND: assert property (up_reg && !inh_n |=> SEGMENT_OUTPUTS == 0
        && COMMON_OUTPUTS == 0 && SHARED_OUTPUT_PINS == 0) else $error("inhibit not grounding");
    AST_INH_OSC: assert property (up_reg && !inh_n |=> !RC_OSC_ENABLE && !OSC_PIN_OE)
        else $error("oscillator live under inhibit");
    AST_INH_SEG: assert property (up_reg && !inh_n |=> SHARED_IS_GP == 4'h0)
        else $error("shared pin general under inhibit");
    AST_PS_ALL: assert property (up_reg && inh_n && PORT_SELECT == 3'h4
        |=> SHARED_IS_GP == 4'hF && SHARED_OUTPUT_PINS == $past(gp_bits))
        else $error("general outputs wrong");
    AST_PS_RSV: assert property (up_reg && inh_n && PORT_SELECT > 3'h4 |=> SHARED_IS_GP == 4'h0)
        else $error("reserved port code");
    AST_RC_ON: assert property (up_reg && inh_n && !POWER_SAVE && !CLOCK_SOURCE_SELECT
        |=> RC_OSC_ENABLE && OSC_PIN_OE) else $error("oscillator not enabled");
    AST_EXT: assert property (up_reg && CLOCK_SOURCE_SELECT |=> !RC_OSC_ENABLE)
        else $error("oscillator on in external mode");
    AST_PSAVE: assert property (up_reg && POWER_SAVE |=> COMMON_OUTPUTS == 0
        && SEGMENT_OUTPUTS == 0 && !RC_OSC_ENABLE) else $error("power save not grounding");
    AST_SEGOFF: assert property (up_reg && SEGMENTS_OFF |=> SEGMENT_OUTPUTS == 0)
        else $error("segments not off");
    AST_COM_HOT: assert property (COMMON_OUTPUTS != 0 |-> COMMON_OUTPUTS == 4'h1 << COMMON_PHASE)
        else $error("common not matching phase");
endmodule
bind lcd_output_decoder lcd_decoder_checker lcd_decoder_checker_i (.*);
`default_nettype wire

// *** tb/lcd_output_decoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcd_output_decoder_tb;
    logic MCLK = 0, RST_B = 0, CLOCK_SOURCE_SELECT = 0, SEGMENTS_OFF = 0, POWER_SAVE = 0;
    logic DISPLAY_INHIBIT_N = 0;
    logic [139:0] DISPLAY_BITS = 0;
    logic [2:0]   FRAME_RATE_SELECT = 0, PORT_SELECT = 0;
    wire RC_OSC_TICK, EXT_CLOCK_TICK, RC_OSC_ENABLE, OSC_PIN_OE, DRIVE_ACTIVE;
    wire [3:0] SHARED_OUTPUT_PINS, SHARED_IS_GP, COMMON_OUTPUTS;
    wire [30:0] SEGMENT_OUTPUTS;
    wire [1:0] COMMON_PHASE;
    int miscompares = 0, cmp_count = 0, n;
    lcd_output_decoder lcd_output_decoder_i (.*);
    osc_source osc_source_i (.clk(MCLK), .rc_en(RC_OSC_ENABLE), .rc_tick(RC_OSC_TICK),
        .ext_tick(EXT_CLOCK_TICK));
    initial forever #2.5 MCLK = ~MCLK;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task settle; repeat (3) @(negedge MCLK); endtask
    task wait_ph;
        logic [1:0] p;
        p = COMMON_PHASE;
        n = 0;
        while (COMMON_PHASE === p && n < 2000) begin
            @(negedge MCLK);
            n++;
        end
    endtask
    task t_inhibit;
        PORT_SELECT = 3'h4;
        DISPLAY_BITS = {140{1'b1}};
        settle;
        chk(SEGMENT_OUTPUTS | COMMON_OUTPUTS | SHARED_OUTPUT_PINS, 0);
        chk(DRIVE_ACTIVE, 0);
        chk(SHARED_IS_GP, 0);
        chk({RC_OSC_ENABLE, OSC_PIN_OE}, 0);
        repeat (2000) @(negedge MCLK);
        DISPLAY_INHIBIT_N = 1;
    endtask
    task t_ports;
        logic [3:0] e;
        DISPLAY_BITS = 140'h101;
        for (int c = 0; c < 8; c++) begin
            PORT_SELECT = c;
            e = (c <= 4) ? (4'h1 << c) - 4'h1 : 4'h0;
            settle;
            chk(SHARED_IS_GP, e);
            chk(SHARED_OUTPUT_PINS & e, 4'h5 & e);
        end
    endtask
    task t_scan;
        logic [30:0] s;
        PORT_SELECT = 0;
        DISPLAY_BITS = {10{14'h2A5B}};
        for (int k = 0; k < 8; k++) begin
            wait_ph;
            @(negedge MCLK);
            for (int i = 0; i < 31; i++) s[i] = DISPLAY_BITS[4 * (i + 4) + COMMON_PHASE];
            chk(SEGMENT_OUTPUTS, s);
            for (int j = 0; j < 4; j++) begin
                chk(SHARED_OUTPUT_PINS[j], DISPLAY_BITS[4 * j + COMMON_PHASE]);
            end
            chk(COMMON_OUTPUTS, 4'h1 << COMMON_PHASE);
        end
    endtask
    task t_rate;
        int q[6] = '{192, 144, 96, 72, 48, 96};
        logic [2:0] code[6] = '{3'h6, 3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
        for (int k = 0; k < 6; k++) begin
            FRAME_RATE_SELECT = code[k];
            wait_ph;
            wait_ph;
            chk(n, 2 * q[k]);
        end
    endtask
    task t_modes;
        POWER_SAVE = 1;
        PORT_SELECT = 3'h2;
        DISPLAY_BITS = 140'h1;
        settle;
        chk({COMMON_OUTPUTS, RC_OSC_ENABLE, DRIVE_ACTIVE}, 0);
        chk(SEGMENT_OUTPUTS, 0);
        chk(SHARED_OUTPUT_PINS, 4'h1);
        POWER_SAVE = 0;
        SEGMENTS_OFF = 1;
        DISPLAY_BITS = {140{1'b1}};
        wait_ph;
        @(negedge MCLK);
        chk(SEGMENT_OUTPUTS, 0);
        chk(COMMON_OUTPUTS, 4'h1 << COMMON_PHASE);
        chk(DRIVE_ACTIVE, 1);
        CLOCK_SOURCE_SELECT = 1;
        settle;
        chk(RC_OSC_ENABLE, 0);
        wait_ph;
        chk(n < 2000, 1);
    endtask
    task give_verdict;
        if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge MCLK);
        RST_B = 1;
        t_inhibit;
        t_ports;
        t_scan;
        t_rate;
        t_modes;
        give_verdict;
    end
    initial begin
        #400000;
        miscompares++;
        give_verdict;
    end
endmodule
`default_nettype wire

// *** tb/osc_source.sv ***
`timescale 1ns/1ps
`default_nettype none
// Display clock sources: one tick every second cycle
module osc_source (
    input  wire logic clk,
    input  wire logic rc_en,
    output var  logic rc_tick,
    output var  logic ext_tick
);
    logic t = 1'b0;
    always @(negedge clk) begin
        t <= ~t;
        rc_tick <= ~t & rc_en;
        ext_tick <= ~t;
    end
endmodule
`default_nettype wire

// *** verilog/frame_divider.v ***
`timescale 1ns/1ps
`default_nettype none
// Divides the display clock ticks into one tick per common phase
module frame_divider (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       tick,
    input  wire       run,
    input  wire [2:0] rate_sel,
    output reg        phase_tick
);
`include "lcd_decoder_defines.vh"

    reg  [9:0] count_reg;
    reg  [9:0] count_next;
    reg  [9:0] div_per_phase;

    function [9:0] frame_div;
        input [2:0] sel;
        begin
            case (sel)
                `FR_768: frame_div = `DIV_768;
                `FR_576: frame_div = `DIV_576;
                `FR_288: frame_div = `DIV_288;
                `FR_192: frame_div = `DIV_192;
                default: frame_div = `DIV_384;
            endcase
        end
    endfunction

    // A frame holds four phases, so each phase lasts a quarter of the divisor
    always @* begin
        div_per_phase = frame_div(rate_sel) >> 2;
        count_next    = count_reg;
        if (!run) begin
            count_next = `COUNT_RESET;
        end else if (tick) begin
            if (count_reg >= div_per_phase - 10'h001) begin
                count_next = `COUNT_RESET;
            end else begin
                count_next = count_reg + 10'h001;
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg  <= `COUNT_RESET;
            phase_tick <= 1'b0;
        end else begin
            count_reg  <= count_next;
            phase_tick <= run && tick && (count_reg >= div_per_phase - 10'h001);
        end
    end
endmodule
`default_nettype wire

// *** verilog/lcd_output_decoder.v ***
`timescale 1ns/1ps
`default_nettype none
module lcd_output_decoder (
    // Clock and reset
    input  wire         MCLK,
    input  wire         RST_B,
    // Latched image and control fields from the serial receiver
    input  wire [139:0] DISPLAY_BITS,
    input  wire [2:0]   FRAME_RATE_SELECT,
    input  wire [2:0]   PORT_SELECT,
    input  wire         CLOCK_SOURCE_SELECT,
    input  wire         SEGMENTS_OFF,
    input  wire         POWER_SAVE,
    // Display inhibit from the controller
    input  wire         DISPLAY_INHIBIT_N,
    // Display clock sources
    input  wire         RC_OSC_TICK,
    input  wire         EXT_CLOCK_TICK,
    // Oscillator pin control
    output reg          RC_OSC_ENABLE,
    output reg          OSC_PIN_OE,
    // Drive levels: on marks a selected level, active high marks common phase
    output reg  [3:0]   SHARED_OUTPUT_PINS,
    output reg  [3:0]   SHARED_IS_GP,
    output reg  [30:0]  SEGMENT_OUTPUTS,
    output reg  [3:0]   COMMON_OUTPUTS,
    output reg          DRIVE_ACTIVE,
    output reg  [1:0]   COMMON_PHASE
);
`include "lcd_decoder_defines.vh"

    wire        display_clock_tick;
    wire        phase_tick;
    wire [3:0]  gp_enable;
    wire        forced_off;
    wire        run;
    reg  [1:0]  phase_reg;
    reg  [1:0]  phase_next;
    reg  [34:0] seg_on;
    reg  [3:0]  shared_next;
    reg  [30:0] segment_next;
    reg  [3:0]  common_next;
    reg         rc_enable_next;
    reg         osc_oe_next;
    integer     n;

    // Display bit of segment n at a given common phase (0-based index)
    function bit_at;
        input [139:0] bits;
        input integer seg;
        input [1:0]   ph;
        begin
            bit_at = bits[4 * seg + ph];
        end
    endfunction

    // Image and control inputs are used as is; nothing here resets them.
    assign forced_off = !DISPLAY_INHIBIT_N || POWER_SAVE;

    // Only one clock source can advance the waveform; the other is ignored
    assign display_clock_tick = CLOCK_SOURCE_SELECT ? EXT_CLOCK_TICK
                                                    : RC_OSC_TICK;
    assign run = !forced_off;

    frame_divider u_frame_divider (
        .clk        (MCLK),
        .rst_b      (RST_B),
        .tick       (display_clock_tick),
        .run        (run),
        .rate_sel   (FRAME_RATE_SELECT),
        .phase_tick (phase_tick)
    );

    shared_pin_mux u_shared_pin_mux (
        .port_select       (PORT_SELECT),
        .display_inhibit_n (DISPLAY_INHIBIT_N),
        .gp_enable         (gp_enable)
    );

    always @* begin
        phase_next = phase_reg;
        if (!run) begin
            phase_next = `PHASE_RESET;
        end else if (phase_tick) begin
            phase_next = phase_reg + 2'h1;
        end
    end

    always @* begin
        for (n = 0; n < `NUM_SEGMENTS; n = n + 1) begin
            // Segments-off blanks without stopping the commons
            seg_on[n] = bit_at(DISPLAY_BITS, n, phase_reg) && !SEGMENTS_OFF;
        end
        segment_next = forced_off ? 31'h00000000 : seg_on[34:4];
        common_next  = forced_off ? 4'h0 : (4'h1 << phase_reg);
        for (n = 0; n < `NUM_SHARED; n = n + 1) begin
            if (gp_enable[n]) begin
                // General outputs keep working in power save
                shared_next[n] = DISPLAY_BITS[4 * n];
            end else begin
                shared_next[n] = forced_off ? 1'b0 : seg_on[n];
            end
        end
        if (!DISPLAY_INHIBIT_N) begin
            shared_next = 4'h0;
        end
        // Oscillator only runs in RC mode with display live
        rc_enable_next = run && !CLOCK_SOURCE_SELECT;
        osc_oe_next    = DISPLAY_INHIBIT_N && !CLOCK_SOURCE_SELECT && !POWER_SAVE;
    end

    always @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_reg          <= `PHASE_RESET;
            SHARED_OUTPUT_PINS <= 4'h0;
            SHARED_IS_GP       <= 4'h0;
            SEGMENT_OUTPUTS    <= 31'h00000000;
            COMMON_OUTPUTS     <= 4'h0;
            DRIVE_ACTIVE       <= 1'b0;
            COMMON_PHASE       <= 2'h0;
            RC_OSC_ENABLE      <= 1'b0;
            OSC_PIN_OE         <= 1'b0;
        end else begin
            phase_reg          <= phase_next;
            SHARED_OUTPUT_PINS <= shared_next;
            SHARED_IS_GP       <= gp_enable;
            SEGMENT_OUTPUTS    <= segment_next;
            COMMON_OUTPUTS     <= common_next;
            DRIVE_ACTIVE       <= run;
            COMMON_PHASE       <= phase_reg;
            RC_OSC_ENABLE      <= rc_enable_next;
            OSC_PIN_OE         <= osc_oe_next;
        end
    end
endmodule
`default_nettype wire

// *** verilog/shared_pin_mux.v ***
`timescale 1ns/1ps
`default_nettype none
// Chooses segment or general-purpose function for the four shared pins
module shared_pin_mux (
    input  wire [2:0] port_select,
    input  wire       display_inhibit_n,
    output reg  [3:0] gp_enable
);
`include "lcd_decoder_defines.vh"

    always @* begin
        case (port_select)
            `PS_NONE:  gp_enable = 4'h0;
            `PS_ONE:   gp_enable = 4'h1;
            `PS_TWO:   gp_enable = 4'h3;
            `PS_THREE: gp_enable = 4'h7;
            `PS_ALL:   gp_enable = 4'hF;
            default:   gp_enable = 4'h0;
        endcase
        if (!display_inhibit_n) begin
            gp_enable = 4'h0;
        end
    end
endmodule
`default_nettype wire
